// File: inc/pcp_pkg.sv
`default_nettype none
package pcp_pkg;
  // ********************************
  // register map, byte addresses
  // ********************************
  localparam logic [7:0] REG_DATA = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ALT_STATUS = 8'h08;
  localparam logic [7:0] REG_COMMAND = 8'h0c;
  localparam logic [7:0] REG_CONTROL = 8'h10;
  localparam logic [7:0] REG_TAG_COUNT = 8'h14;
  localparam logic [7:0] REG_ERROR = 8'h18;

  // control register fields and reset values
  localparam int CTRL_NIEN = 0;
  localparam int CTRL_SVC_IE = 1;
  localparam logic CTRL_NIEN_RESET = 1'b0;
  localparam logic CTRL_SVC_IE_RESET = 1'b0;
  // tag and byte count register fields
  localparam int TAG_LSB = 0;
  localparam int COUNT_LSB = 16;

  // command opcodes, values are arbitrary
  localparam logic [7:0] OP_PACKET = 8'h01;
  localparam logic [7:0] OP_SERVICE = 8'h02;
  // command packet length in bytes
  localparam logic [15:0] PKT_BYTES = 16'h000c;

  // ********************************
  // timing
  // ********************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_CMD_BUSY_NS = 400;
  // longest time: round down, at least one cycle
  localparam int CMD_BUSY_CYC = (T_CMD_BUSY_NS / CLK_PERIOD_NS < 1) ? 1 :
                                T_CMD_BUSY_NS / CLK_PERIOD_NS;

  // ********************************
  // types
  // ********************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PREP_A = 3'b001,
    ST_RECV_PKT = 3'b010,
    ST_PREP_B = 3'b011,
    ST_READY_INT = 3'b100,
    ST_XFER = 3'b101
  } pcp_state_e;

  // status byte: [7]bsy [6]rel [5]serv [4]drq [3]cd [2]io [1]ipend [0]err
  typedef struct packed {
    logic bsy;
    logic rel;
    logic serv;
    logic drq;
    logic cd;
    logic io;
  } pcp_stat_s;
  localparam pcp_stat_s STAT_RESET = 6'h00;

  // from the device's command engine
  typedef struct packed {
    logic pkt_ready;
    logic blk_ready;
    logic done;
    logic abort;
    logic released;
    logic other_rel;
    logic other_ready;
    logic dir_out;
    logic [7:0] err;
    logic [4:0] tag;
    logic [15:0] byte_cnt;
    logic [15:0] blk_words;
    logic [15:0] rd_data;
  } pcp_be_s;

  // to the device's command engine
  typedef struct packed {
    logic pkt_valid;
    logic wr_valid;
    logic rd_taken;
    logic [15:0] data;
  } pcp_dev_s;
endpackage
`default_nettype wire

// File: design/pcp_word_counter.sv
`timescale 1ns/1ns
`default_nettype none
module pcp_word_counter (
  input wire logic clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [15:0] load_val,
  input wire logic step,
  output logic last,
  output logic [15:0] count
);
  // an empty block is treated as one word so the transfer can still end
  always_ff @(posedge clk) begin
    if (reset) begin
      count <= 16'h0000;
    end else if (load) begin
      count <= (load_val == 16'h0000) ? 16'h0001 : load_val;
    end else if (step && count != 16'h0000) begin
      count <= count - 16'h0001;
    end
  end

  assign last = (count == 16'h0001);
endmodule
`default_nettype wire

// File: design/pcp_device.sv
`timescale 1ns/1ns
`default_nettype none
module pcp_device (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire pcp_pkg::pcp_be_s be_in,
  output var pcp_pkg::pcp_dev_s dev_out,
  output logic intrq
);
  import pcp_pkg::*;

  pcp_state_e state;
  pcp_stat_s stat;
  logic ack, go, wen;
  logic nien, svc_ie, ipend, svc_mode;
  logic [7:0] err;
  logic [4:0] tag;
  logic [15:0] byte_cnt;
  logic cmd_wr, pkt_cmd, svc_cmd, stat_rd;
  logic data_wr, data_rd, data_acc;
  logic pb_svc;
  logic pb_blk;
  logic pb_end;
  logic pa_abort;
  logic to_idle;
  logic enter_recv;
  logic enter_pb;
  logic enter_dreq;
  logic cnt_load;
  logic [15:0] cnt_val;
  logic cnt_step;
  logic cnt_last;

  // ********************************
  // bus slave
  // ********************************
  // one wait state: the answer is taken at the second edge of a request
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign go = (avs_read | avs_write) & ack;
  assign wen = avs_write & avs_byteenable[0];

  always_ff @(posedge clk) begin
    if (reset) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  assign cmd_wr = go & wen & (avs_address == REG_COMMAND);
  assign pkt_cmd = cmd_wr & (avs_writedata[7:0] == OP_PACKET);
  assign svc_cmd = cmd_wr & (avs_writedata[7:0] == OP_SERVICE);
  assign stat_rd = go & avs_read & (avs_address == REG_STATUS);
  assign data_wr = go & wen & (avs_address == REG_DATA);
  assign data_rd = go & avs_read & (avs_address == REG_DATA);
  assign data_acc = data_wr | data_rd;

  // read data is sampled before the side effects of the same read
  always_ff @(posedge clk) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
      unique case (avs_address)
        REG_DATA: avs_readdata <= {16'h0000, be_in.rd_data};
        REG_STATUS, REG_ALT_STATUS: avs_readdata <= {24'h0000_00, stat, ipend, |err};
        REG_CONTROL: avs_readdata <= {30'h0000_0000, svc_ie, nien};
        REG_TAG_COUNT: avs_readdata <= {byte_cnt, 11'h000, tag};
        REG_ERROR: avs_readdata <= {24'h0000_00, err};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      nien <= CTRL_NIEN_RESET;
      svc_ie <= CTRL_SVC_IE_RESET;
    end else if (go && wen && avs_address == REG_CONTROL) begin
      nien <= avs_writedata[CTRL_NIEN];
      svc_ie <= avs_writedata[CTRL_SVC_IE];
    end
  end

  // ********************************
  // protocol decode
  // ********************************
  // preparing: service command first, then data block, then completion
  assign pb_svc = (state == ST_PREP_B) & svc_ie & svc_cmd;
  assign pb_blk = (state == ST_PREP_B) & ~pb_svc & be_in.blk_ready;
  assign pb_end = (state == ST_PREP_B) & ~pb_svc & ~be_in.blk_ready &
                  (be_in.done | be_in.abort | be_in.released);
  // an invalid queued tag is reported by the engine as an abort
  assign pa_abort = (state == ST_PREP_A) & be_in.abort;
  assign to_idle = pb_end | pa_abort;
  assign enter_recv = (state == ST_PREP_A) & ~be_in.abort & be_in.pkt_ready;
  assign enter_dreq = pb_svc | pb_blk;
  assign enter_pb = ((state == ST_RECV_PKT) & data_wr & cnt_last) |
                    ((state == ST_READY_INT) & stat_rd & svc_mode) |
                    ((state == ST_XFER) & data_acc & cnt_last) |
                    ((state == ST_IDLE) & svc_cmd & stat.serv);

  // ********************************
  // state machine
  // ********************************
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (pkt_cmd) begin
            state <= ST_PREP_A;
          end else if (svc_cmd && stat.serv) begin
            state <= ST_PREP_B;
          end
        end
        ST_PREP_A: begin
          if (pa_abort) begin
            state <= ST_IDLE;
          end else if (enter_recv) begin
            state <= ST_RECV_PKT;
          end
        end
        ST_RECV_PKT: begin
          if (data_wr && cnt_last) begin
            state <= ST_PREP_B;
          end
        end
        ST_PREP_B: begin
          if (pb_svc) begin
            state <= ST_READY_INT;
          end else if (pb_blk) begin
            state <= nien ? ST_XFER : ST_READY_INT;
          end else if (pb_end) begin
            state <= ST_IDLE;
          end
        end
        ST_READY_INT: begin
          if (stat_rd) begin
            state <= svc_mode ? ST_PREP_B : ST_XFER;
          end
        end
        ST_XFER: begin
          if (data_acc && cnt_last) begin
            state <= ST_PREP_B;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      svc_mode <= 1'b0;
    end else if (enter_dreq) begin
      svc_mode <= pb_svc;
    end
  end

  // ********************************
  // status flags
  // ********************************
  always_ff @(posedge clk) begin
    if (reset) begin
      stat <= STAT_RESET;
    end else begin
      if (pkt_cmd && state == ST_IDLE) begin
        stat.bsy <= 1'b1;
        stat.drq <= 1'b0;
      end
      if (enter_pb) begin
        stat.bsy <= 1'b1;
        stat.drq <= 1'b0;
        if (state == ST_IDLE) begin
          stat.serv <= 1'b0;
        end
      end
      if (enter_recv) begin
        stat.bsy <= 1'b0;
        stat.drq <= 1'b1;
        stat.cd <= 1'b1;
        stat.io <= 1'b0;
        stat.rel <= 1'b0;
      end
      if (enter_dreq) begin
        stat.bsy <= 1'b0;
        stat.drq <= 1'b1;
        stat.cd <= 1'b0;
        stat.io <= be_in.dir_out;
        stat.rel <= 1'b0;
        stat.serv <= 1'b0;
      end
      if (to_idle) begin
        stat.bsy <= 1'b0;
        stat.drq <= 1'b0;
        stat.cd <= 1'b1;
        stat.io <= 1'b1;
        stat.rel <= pb_end & be_in.released;
        stat.serv <= be_in.other_ready;
      end
    end
  end

  // error bits are loaded on every idle entry, cleared by a new packet
  always_ff @(posedge clk) begin
    if (reset) begin
      err <= 8'h00;
    end else if (to_idle) begin
      err <= be_in.err;
    end else if (pkt_cmd && state == ST_IDLE) begin
      err <= 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tag <= 5'h00;
      byte_cnt <= 16'h0000;
    end else if (enter_dreq) begin
      tag <= be_in.tag;
      byte_cnt <= be_in.byte_cnt;
    end
  end

  // ********************************
  // interrupt pending
  // ********************************
  // set terms come last so a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (reset) begin
      ipend <= 1'b0;
    end else begin
      if ((pkt_cmd && state == ST_IDLE) || enter_pb) begin
        ipend <= 1'b0;
      end
      if (state == ST_READY_INT && stat_rd) begin
        ipend <= 1'b0;
      end
      if (enter_dreq) begin
        ipend <= 1'b1;
      end
      if (to_idle && !nien) begin
        ipend <= 1'b1;
      end
    end
  end

  assign intrq = ipend & ~nien;

  // ********************************
  // packet and data path
  // ********************************
  assign cnt_load = enter_recv | enter_dreq;
  assign cnt_val = enter_recv ? PKT_BYTES : be_in.blk_words;
  assign cnt_step = ((state == ST_RECV_PKT) & data_wr) | ((state == ST_XFER) & data_acc);

  pcp_word_counter u_count (
    .clk(clk),
    .reset(reset),
    .load(cnt_load),
    .load_val(cnt_val),
    .step(cnt_step),
    .last(cnt_last),
    .count()
  );

  // data accesses outside receive and transfer are dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      dev_out <= '0;
    end else begin
      dev_out.pkt_valid <= (state == ST_RECV_PKT) & data_wr;
      dev_out.wr_valid <= (state == ST_XFER) & data_wr;
      dev_out.rd_taken <= (state == ST_XFER) & data_rd;
      if (data_wr) begin
        dev_out.data <= avs_writedata[15:0];
      end
    end
  end

  // ********************************
  // checks
  // ********************************
  localparam int CmdCyc = CMD_BUSY_CYC;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest)
    else $error("bus request not answered after one wait state");
  a_cmd_busy: assert property (pkt_cmd && state == ST_IDLE |-> ##[1:CmdCyc]
    (stat.bsy && !stat.drq && !intrq))
    else $error("busy not raised after packet command");
  a_svc_ready: assert property (pb_svc |=> state == ST_READY_INT &&
    tag == $past(be_in.tag))
    else $error("service command did not reach ready interrupt");
  a_idle_intr: assert property (pb_end && !nien |=> state == ST_IDLE && intrq &&
    stat.cd && stat.io && !stat.bsy && err == $past(be_in.err))
    else $error("idle entry with interrupt wrong");
  a_idle_quiet: assert property (pb_end && nien |=> !ipend && !stat.bsy &&
    stat.cd)
    else $error("idle entry without interrupt wrong");
  a_idle_flags: assert property (pb_end |=> stat.serv == $past(be_in.other_ready) &&
    stat.rel == $past(be_in.released))
    else $error("release or service flag wrong on idle entry");
  a_rdy_pins: assert property (state == ST_READY_INT && !nien |-> !stat.bsy &&
    stat.drq && !stat.cd && intrq)
    else $error("ready interrupt outputs wrong");
  a_rdy_exit: assert property (state == ST_READY_INT && stat_rd && !svc_mode |=>
    state == ST_XFER && !intrq && !ipend)
    else $error("status read did not start transfer");
  a_svc_return: assert property (state == ST_READY_INT && stat_rd && svc_mode |=>
    state == ST_PREP_B && stat.bsy)
    else $error("service read did not return to preparing");
  a_xfer_pins: assert property (state == ST_XFER |-> !stat.bsy && stat.drq &&
    !stat.cd)
    else $error("transfer outputs wrong");
  a_blk_end: assert property (state == ST_XFER && data_acc && cnt_last |=>
    state == ST_PREP_B && stat.bsy && !stat.drq)
    else $error("block end did not return to preparing");
  a_direct_xfer: assert property (pb_blk && nien |=> state == ST_XFER && ipend &&
    !intrq)
    else $error("block ready with interrupts off wrong");

  c_packet_sent: cover property (state == ST_RECV_PKT ##1 state == ST_PREP_B);
  c_data_block: cover property (state == ST_READY_INT ##1 state == ST_XFER);
  c_release: cover property (pb_end && be_in.released);
  c_service: cover property (pb_svc);
endmodule
`default_nettype wire

// File: sim/pcp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module pcp_host_model (
  input wire logic clk,
  output logic [7:0] address,
  output logic read,
  output logic write,
  output logic [3:0] byteenable,
  output logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  import pcp_pkg::*;
  // ****************************************
  // bus master
  // ****************************************
  int stalls = 0;
  initial begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h1;
    writedata = 32'h0000_0000;
  end
  // hold the request until waitrequest is seen low; any count but one wait state is counted
  task automatic bus(input logic wr_n, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    read <= !wr_n;
    write <= wr_n;
    writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest);
    if (n != 2) stalls++;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  // ****************************************
  // packet command issue
  // ****************************************
  task automatic send_packet();
    logic [31:0] q;
    int n;
    wr(REG_COMMAND, {24'h00_0000, OP_PACKET});
    repeat (CMD_BUSY_CYC) @(posedge clk);
    n = 0;
    do begin
      rd(REG_STATUS, q);
      n++;
    end while (q[7] && n < 32);
    if (q[4]) begin
      for (int i = 0; i < PKT_BYTES; i++) wr(REG_DATA, 32'h0000_00a0 + i);
    end
    // discarded read stands in for the pause before the second check
    rd(REG_ALT_STATUS, q);
  endtask
endmodule
`default_nettype wire

// File: sim/packet_command_protocol_fsm_tb.sv
`timescale 1ns/1ns
`default_nettype none
module packet_command_protocol_fsm_tb;
  import pcp_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  wire logic [7:0] avs_address;
  wire logic avs_read;
  wire logic avs_write;
  wire logic [3:0] avs_byteenable;
  wire logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  pcp_be_s be = '0;
  pcp_dev_s dev_out;
  logic intrq;
  int n_errors = 0;
  int comparisons = 0;
  int n_pkt = 0;
  int n_acc = 0;
  always #50 clk = ~clk;
  pcp_device u_pcp_device (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .be_in(be), .dev_out(dev_out), .intrq(intrq));
  pcp_host_model u_pcp_host_model (.clk(clk), .address(avs_address), .read(avs_read),
    .write(avs_write), .byteenable(avs_byteenable), .writedata(avs_writedata),
    .readdata(avs_readdata), .waitrequest(avs_waitrequest));
  always @(posedge clk) begin
    n_pkt <= n_pkt + int'(dev_out.pkt_valid);
    n_acc <= n_acc + int'(dev_out.wr_valid) + int'(dev_out.rd_taken);
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    be <= '0;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_regs();
    logic [31:0] q;
    u_pcp_host_model.wr(8'hfc, 32'h0000_0003);
    u_pcp_host_model.rd(REG_STATUS, q);
    check(q, 32'h0000_0000, "status at reset");
    u_pcp_host_model.rd(REG_CONTROL, q);
    check(q, 32'h0000_0000, "control at reset");
    u_pcp_host_model.rd(8'hfc, q);
    check(q, 32'h0000_0000, "unmapped read");
    check(intrq, 1'b0, "intrq at reset");
    $display("test reset_regs done");
  endtask
  task automatic t_packet();
    logic [31:0] q;
    int p0;
    u_pcp_host_model.wr(REG_COMMAND, {24'h00_0000, OP_PACKET});
    u_pcp_host_model.rd(REG_ALT_STATUS, q);
    check(q[7:0], 8'h80, "busy after packet");
    check(intrq, 1'b0, "intrq after packet");
    p0 = n_pkt;
    be.pkt_ready <= 1'b1;
    u_pcp_host_model.send_packet();
    u_pcp_host_model.rd(REG_ALT_STATUS, q);
    check(n_pkt - p0, 32'd12, "packet bytes");
    check(q[7:0] & 8'h90, 8'h80, "preparing after packet");
    $display("test packet done");
  endtask
  task automatic t_block(input logic nien, input logic dir);
    logic [31:0] q;
    int a0;
    u_pcp_host_model.wr(REG_CONTROL, {31'h0000_0000, nien});
    u_pcp_host_model.send_packet();
    be.dir_out <= dir;
    be.blk_words <= 16'h0003;
    be.rd_data <= 16'h5a3c;
    be.blk_ready <= 1'b1;
    repeat (2) @(posedge clk);
    be.blk_ready <= 1'b0;
    u_pcp_host_model.rd(REG_ALT_STATUS, q);
    check(q[7:0], 8'h12 | {5'b00000, dir, 2'b00}, "block state");
    check(intrq, !nien, "intrq on block");
    u_pcp_host_model.rd(REG_STATUS, q);
    u_pcp_host_model.rd(REG_ALT_STATUS, q);
    check(q[7:0] & 8'h9c, 8'h10 | {5'b00000, dir, 2'b00}, "transfer state");
    check(intrq, 1'b0, "intrq in transfer");
    a0 = n_acc;
    for (int i = 0; i < 3; i++) begin
      if (dir) u_pcp_host_model.wr(REG_DATA, 32'h0000_c350 + i);
      else u_pcp_host_model.rd(REG_DATA, q);
    end
    if (!dir) check(q[15:0], 16'h5a3c, "data word in");
    u_pcp_host_model.rd(REG_ALT_STATUS, q);
    check(n_acc - a0, 32'd3, "words moved");
    if (dir) check(dev_out.data, 16'hc352, "data word out");
    check(q[7:0] & 8'h90, 8'h80, "back to preparing");
    be.done <= 1'b1;
    repeat (2) @(posedge clk);
    be.done <= 1'b0;
    $display("test block nien %0b dir %0b done", nien, dir);
  endtask
  task automatic t_finish();
    logic [5:0] cases [6] = '{6'b010000, 6'b101000, 6'b010010,
                              6'b110001, 6'b000100, 6'b100101};
    logic [31:0] q;
    logic [7:0] exp;
    for (int i = 0; i < 6; i++) begin
      u_pcp_host_model.wr(REG_CONTROL, {31'h0000_0000, cases[i][5]});
      u_pcp_host_model.send_packet();
      be.err <= {7'h00, i[0]};
      {be.done, be.abort, be.released, be.other_rel, be.other_ready} <= cases[i][4:0];
      repeat (2) @(posedge clk);
      {be.done, be.abort, be.released, be.other_rel, be.other_ready} <= 5'b00000;
      u_pcp_host_model.rd(REG_ALT_STATUS, q);
      exp = {1'b0, cases[i][2], cases[i][0], 1'b0, 2'b11, !cases[i][5], i[0]};
      check(q[7:0], exp, "idle entry status");
      check(intrq, !cases[i][5], "idle entry intrq");
      u_pcp_host_model.rd(REG_ERROR, q);
      check(q, {31'h0000_0000, i[0]}, "error bits");
      be.err <= 8'h00;
    end
    // queued service from idle, then an engine abort while preparing the packet
    u_pcp_host_model.wr(REG_COMMAND, {24'h00_0000, OP_SERVICE});
    u_pcp_host_model.rd(REG_ALT_STATUS, q);
    check(q[7:0] & 8'hb0, 8'h80, "service from idle");
    be.done <= 1'b1;
    repeat (2) @(posedge clk);
    be.done <= 1'b0;
    be.abort <= 1'b1;
    u_pcp_host_model.wr(REG_COMMAND, {24'h00_0000, OP_PACKET});
    @(posedge clk);
    be.abort <= 1'b0;
    u_pcp_host_model.rd(REG_ALT_STATUS, q);
    check(q[7:0] & 8'h9c, 8'h0c, "bad tag abort");
    $display("test finish done");
  endtask
  task automatic t_service();
    logic [31:0] q;
    u_pcp_host_model.wr(REG_CONTROL, 32'h0000_0000);
    u_pcp_host_model.send_packet();
    be.tag <= 5'h15;
    be.byte_cnt <= 16'h0200;
    u_pcp_host_model.wr(REG_COMMAND, {24'h00_0000, OP_SERVICE});
    u_pcp_host_model.rd(REG_ALT_STATUS, q);
    check(q[7], 1'b1, "service refused");
    u_pcp_host_model.wr(REG_CONTROL, 32'h0000_0002);
    u_pcp_host_model.wr(REG_COMMAND, {24'h00_0000, OP_SERVICE});
    u_pcp_host_model.rd(REG_ALT_STATUS, q);
    check(q[7:0] & 8'h98, 8'h10, "service ready");
    check(intrq, 1'b1, "service intrq");
    u_pcp_host_model.rd(REG_TAG_COUNT, q);
    check(q, 32'h0200_0015, "tag and count");
    u_pcp_host_model.rd(REG_STATUS, q);
    u_pcp_host_model.rd(REG_ALT_STATUS, q);
    check(q[7:0] & 8'h90, 8'h80, "service return");
    do_reset();
    u_pcp_host_model.rd(REG_STATUS, q);
    check(q, 32'h0000_0000, "status after reset");
    check(intrq, 1'b0, "intrq after reset");
    $display("test service done");
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    do_reset();
    t_reset_regs();
    t_packet();
    be.done <= 1'b1;
    repeat (2) @(posedge clk);
    be.done <= 1'b0;
    t_block(1'b0, 1'b0);
    t_block(1'b1, 1'b1);
    t_block(1'b0, 1'b1);
    t_finish();
    t_service();
    check(u_pcp_host_model.stalls, 32'd0, "bus stalls");
    results();
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
